// [chcfg_pkg.sv]
`default_nettype none
package chcfg_pkg;

  // channel count and configuration word layout
  localparam int CHAN_COUNT   = 8;
  localparam int PAGE_W       = 3;
  localparam int CFG_W        = 16;
  localparam int MODE_HI      = 15;
  localparam int MODE_LO      = 14;
  localparam int FAST_SERVO_OFF_BIT = 11;
  localparam int SUP_RES_BIT  = 10;
  localparam int ADC_HIRES_BIT = 9;
  localparam int CTRL_SEL_BIT = 8;
  localparam int SERVO_CONT_BIT = 7;
  localparam int SERVO_WARN_BIT = 6;
  localparam int DAC_MODE_HI  = 5;
  localparam int DAC_MODE_LO  = 4;
  localparam int WPU_BIT      = 3;
  localparam int WPD_BIT      = 2;
  localparam int DAC_GAIN_BIT = 1;
  localparam int DAC_POL_BIT  = 0;

  // bits 13:12 never store and read back as zero
  localparam logic [CFG_W-1:0] CFG_KEEP_MASK = 16'hcfff;
  localparam logic [CFG_W-1:0] CFG_RESET     = 16'h0000;

  // channels below this index own the pull-up and pull-down styles
  localparam int ENABLE_STYLE_CHANS = 4;

  // sequencing modes of the two-bit mode field
  localparam logic [1:0] SEQ_IMMEDIATE = 2'h0;
  localparam logic [1:0] SEQ_SEQUENCED = 2'h1;

  typedef enum logic [1:0] {
    DAC_SERVO  = 2'b00,
    DAC_OFF    = 2'b01,
    DAC_DIRECT = 2'b10,
    DAC_SOFT   = 2'b11
  } chcfg_dac_mode_type;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_DELAY = 3'b001,
    ST_RISE  = 3'b010,
    ST_ON    = 3'b011,
    ST_TOFF  = 3'b100
  } chcfg_state_type;

  // synchronised pin bundle layout
  localparam int PIN_W       = 36;
  localparam int PIN_CTRL_A  = 35;
  localparam int PIN_CTRL_B  = 34;
  localparam int PIN_SHARE   = 33;
  localparam int PIN_VIN_OFF = 32;
  localparam int PIN_FAULT_LO = 24;
  localparam int PIN_UV_LO   = 16;
  localparam int PIN_OVW_LO  = 8;
  localparam int PIN_UVW_LO  = 0;
  // shared clock idles high, everything else low
  localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 36'h200000000;

  // timing, clock at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int TON_DELAY_NS  = 100000;
  localparam int TON_RISE_NS   = 200000;
  localparam int TON_MAX_NS    = 400000;
  localparam int TOFF_DELAY_NS = 100000;
  localparam int TON_DELAY_CYCLES = (TON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TON_RISE_CYCLES  = (TON_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TON_MAX_CYCLES   = (TON_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_DELAY_CYCLES = (TOFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 13;

endpackage : chcfg_pkg
`default_nettype wire

// [chcfg_sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface chcfg_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : chcfg_sync_if
`default_nettype wire

// [chcfg_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module chcfg_sync #(
  parameter int            W         = 1,
  parameter logic [W-1:0]  RESET_VAL = '0
) (
  input  wire logic    clk_sys,
  input  wire logic    reset_n,
  input  wire logic    clk_en,
  chcfg_sync_if.sync   pins
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] held;

  // a bit moves only once stages two and three agree, so one-cycle glitches are dropped
  wire  [W-1:0] agree      = ~(stage2 ^ stage3);
  wire  [W-1:0] next_held  = (agree & stage3) | (~agree & held);

  assign pins.clean = held;

  // three-flop chain; stage1 feeds stage2 only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      held   <= RESET_VAL;
    end
    else if (clk_en)
    begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      held   <= next_held;
    end
  end

endmodule : chcfg_sync
`default_nettype wire

// [chcfg_top.sv]
`timescale 1ns/10ps
`default_nettype none
module chcfg_top
  import chcfg_pkg::*;
#(
  parameter logic [CNT_W-1:0] TON_DELAY_CYC  = CNT_W'(TON_DELAY_CYCLES),
  parameter logic [CNT_W-1:0] TON_RISE_CYC   = CNT_W'(TON_RISE_CYCLES),
  parameter logic [CNT_W-1:0] TON_MAX_CYC    = CNT_W'(TON_MAX_CYCLES),
  parameter logic [CNT_W-1:0] TOFF_DELAY_CYC = CNT_W'(TOFF_DELAY_CYCLES)
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic [PAGE_W-1:0]     page,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  input  wire logic [CFG_W-1:0]      cfg_wdata,
  output var  logic [CFG_W-1:0]      cfg_rdata,
  output var  logic                  cfg_rvalid,
  input  wire logic [CHAN_COUNT-1:0] op_on,
  input  wire logic                  restore_user,
  input  wire logic                  control_input_a,
  input  wire logic                  control_input_b,
  input  wire logic                  share_clk_in,
  input  wire logic                  input_sense_off,
  input  wire logic [CHAN_COUNT-1:0] fault_in,
  input  wire logic [CHAN_COUNT-1:0] uv_in,
  input  wire logic [CHAN_COUNT-1:0] ov_warn_in,
  input  wire logic [CHAN_COUNT-1:0] uv_warn_in,
  input  wire logic [CHAN_COUNT-1:0] target_reached,
  output logic      [CHAN_COUNT-1:0] vout_en_out,
  output logic      [CHAN_COUNT-1:0] vout_en_oe_n,
  output logic      [CHAN_COUNT-1:0] vout_en_weak,
  output logic      [CHAN_COUNT-1:0] uv_report,
  output logic      [CHAN_COUNT-1:0] servo_enable,
  output logic      [CHAN_COUNT-1:0] dac_soft_connect,
  output logic      [CHAN_COUNT-1:0] dac_direct_connect,
  output logic      [CHAN_COUNT-1:0] fast_servo_enable,
  output logic      [CHAN_COUNT-1:0] supervisor_low_res,
  output logic      [CHAN_COUNT-1:0] adc_fine_res,
  output logic      [CHAN_COUNT-1:0] dac_gain_high,
  output logic      [CHAN_COUNT-1:0] dac_pol_noninv,
  output logic      [CHAN_COUNT-1:0] channel_off
);

  // per-channel configuration store
  logic [CFG_W-1:0]      cfg_mem [CHAN_COUNT];
  logic [CHAN_COUNT-1:0] leaving;
  logic [CHAN_COUNT-1:0] tracking;

  // pins from outside the clock domain
  chcfg_sync_if #(.W(PIN_W)) pin_if ();

  assign pin_if.raw = {control_input_a, control_input_b, share_clk_in, input_sense_off,
                       fault_in, uv_in, ov_warn_in, uv_warn_in};

  chcfg_sync #(
    .W         (PIN_W),
    .RESET_VAL (PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pins    (pin_if)
  );

  // named views of the cleaned pins
  wire                  ctrl_a    = pin_if.clean[PIN_CTRL_A];
  wire                  ctrl_b    = pin_if.clean[PIN_CTRL_B];
  wire                  share_low = ~pin_if.clean[PIN_SHARE];
  wire                  vin_off   = pin_if.clean[PIN_VIN_OFF];
  wire [CHAN_COUNT-1:0] fault_c   = pin_if.clean[PIN_FAULT_LO +: CHAN_COUNT];
  wire [CHAN_COUNT-1:0] uv_c      = pin_if.clean[PIN_UV_LO +: CHAN_COUNT];
  wire [CHAN_COUNT-1:0] ovw_c     = pin_if.clean[PIN_OVW_LO +: CHAN_COUNT];
  wire [CHAN_COUNT-1:0] uvw_c     = pin_if.clean[PIN_UVW_LO +: CHAN_COUNT];

  // device-wide down conditions and the tracking group's shared stop
  wire global_down       = vin_off | share_low | restore_user;
  wire track_group_down  = (|fault_c) | (|(leaving & tracking));

  // register access decode
  wire                   wr_hit     = cfg_wr;
  wire [CFG_W-1:0]       wr_value   = cfg_wdata & CFG_KEEP_MASK;
  wire [CFG_W-1:0]       rd_value   = cfg_mem[page] & CFG_KEEP_MASK;

  // configuration words, one per page
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < CHAN_COUNT; k++)
        cfg_mem[k] <= CFG_RESET;
    end
    else if (clk_en && wr_hit)
    begin
      cfg_mem[page] <= wr_value;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata  <= CFG_RESET;
      cfg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rd_value;
    end
  end

  genvar i;
  generate
    for (i = 0; i < CHAN_COUNT; i++)
    begin : g_chan
      localparam bit HAS_STYLE = (i < ENABLE_STYLE_CHANS);
      localparam bit IS_ODD    = (i % 2) == 1;

      wire [CFG_W-1:0]         cfg       = cfg_mem[i];
      wire [1:0]               seq_mode  = cfg[MODE_HI:MODE_LO];
      wire                     is_track  = cfg[MODE_HI];
      wire                     imm_off   = (seq_mode == SEQ_IMMEDIATE);
      wire chcfg_dac_mode_type dac_mode  = chcfg_dac_mode_type'(cfg[DAC_MODE_HI:DAC_MODE_LO]);
      wire                     pu_eff    = HAS_STYLE & cfg[WPU_BIT];
      wire                     pd_eff    = HAS_STYLE & cfg[WPD_BIT];
      wire                     ctrl_sel  = cfg[CTRL_SEL_BIT] ? ctrl_b : ctrl_a;
      wire                     run_req   = op_on[i] & ctrl_sel & ~global_down;
      wire                     own_fault = fault_c[i];
      // a slave also stops when its group stops; sequenced, never abrupt
      wire                     group_hit = is_track & track_group_down;
      wire                     stop_req  = ~run_req | group_hit;

      chcfg_state_type  state;
      chcfg_state_type  next_state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] next_cnt;
      logic [CNT_W-1:0] max_cnt;
      logic [CNT_W-1:0] next_max_cnt;
      logic             fault_off;
      logic             next_fault_off;
      logic             reservo;
      logic             en_q;
      logic             oe_n_q;
      logic             weak_q;
      logic             uv_q;
      logic             servo_q;
      logic             soft_q;
      logic             direct_q;
      logic             leave_q;
      logic             fast_q;
      logic             sup_q;
      logic             adc_q;
      logic             gain_q;
      logic             pol_q;
      logic             off_q;

      // servo control in DAC mode 00
      wire servo_mode   = (dac_mode == DAC_SERVO);
      wire warn_hit     = ovw_c[i] | uvw_c[i];
      wire reservo_set  = (state == ST_ON) & servo_mode & ~cfg[SERVO_CONT_BIT]
                          & cfg[SERVO_WARN_BIT] & warn_hit;
      wire next_reservo = reservo_set | (reservo & ~target_reached[i]);
      wire servo_run    = (state == ST_ON) & servo_mode
                          & (cfg[SERVO_CONT_BIT] | ~target_reached[i] | reservo);

      // UV is blind while rising, inside the max-fault window, and in a slave's off delay
      wire uv_blind = (state != ST_ON && state != ST_TOFF) | (max_cnt != '0)
                      | (is_track & (state == ST_TOFF));

      // enable pin asserted from rise through the end of the off delay
      wire next_en = (next_state == ST_RISE) | (next_state == ST_ON) | (next_state == ST_TOFF);

      // sequencing state machine
      always_comb
      begin
        next_state     = state;
        next_cnt       = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_max_cnt   = (max_cnt != '0) ? max_cnt - 1'b1 : max_cnt;
        next_fault_off = fault_off & run_req;  // a control toggle rearms after a fault
        case (state)
          ST_OFF:
          begin
            next_max_cnt = '0;
            if (run_req && !fault_off && !group_hit)
            begin
              next_state = ST_DELAY;
              next_cnt   = TON_DELAY_CYC;
            end
          end
          ST_DELAY:
          begin
            if (own_fault)
            begin
              next_state     = ST_OFF;
              next_fault_off = 1'b1;
            end
            else if (stop_req)
              next_state = ST_OFF;
            else if (cnt == '0)
            begin
              next_state   = ST_RISE;
              next_cnt     = TON_RISE_CYC;
              next_max_cnt = TON_MAX_CYC;
            end
          end
          ST_RISE, ST_ON:
          begin
            if (own_fault)
            begin
              next_fault_off = 1'b1;
              next_state     = imm_off ? ST_OFF : ST_TOFF;
              next_cnt       = TOFF_DELAY_CYC;
            end
            else if (stop_req)
            begin
              next_state = ST_TOFF;
              next_cnt   = TOFF_DELAY_CYC;
            end
            else if (state == ST_RISE && cnt == '0)
              next_state = ST_ON;
          end
          ST_TOFF:
          begin
            if (own_fault && imm_off)
            begin
              next_state     = ST_OFF;
              next_fault_off = 1'b1;
            end
            else if (cnt == '0)
              next_state = ST_OFF;
          end
          default:
            next_state = ST_OFF;
        endcase
      end

      // sequencer state
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          state     <= ST_OFF;
          cnt       <= '0;
          max_cnt   <= '0;
          fault_off <= 1'b0;
          reservo   <= 1'b0;
        end
        else if (clk_en)
        begin
          state     <= next_state;
          cnt       <= next_cnt;
          max_cnt   <= next_max_cnt;
          fault_off <= next_fault_off;  // a new fault wins over the rearm
          reservo   <= next_reservo;  // a new warning wins over target reached
        end
      end

      // enable pin style and analog control outputs, all registered
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          en_q     <= 1'b0;
          oe_n_q   <= 1'b0;
          weak_q   <= 1'b0;
          uv_q     <= 1'b0;
          servo_q  <= 1'b0;
          soft_q   <= 1'b0;
          direct_q <= 1'b0;
          leave_q  <= 1'b0;
          fast_q   <= 1'b1;
          sup_q    <= 1'b0;
          adc_q    <= 1'b0;
          gain_q   <= 1'b0;
          pol_q    <= 1'b0;
          off_q    <= 1'b1;
        end
        else if (clk_en)
        begin
          en_q     <= next_en;
          oe_n_q   <= next_en & ~pu_eff;
          weak_q   <= next_en ? pu_eff : (pd_eff & ~next_fault_off);
          uv_q     <= uv_c[i] & ~uv_blind;
          servo_q  <= servo_run;
          soft_q   <= (state == ST_ON) & (servo_mode | (dac_mode == DAC_SOFT));
          direct_q <= (state == ST_ON) & (dac_mode == DAC_DIRECT);
          leave_q  <= (next_state == ST_TOFF);
          fast_q   <= ~cfg[FAST_SERVO_OFF_BIT];
          sup_q    <= cfg[SUP_RES_BIT];
          adc_q    <= IS_ODD & cfg[ADC_HIRES_BIT];
          gain_q   <= cfg[DAC_GAIN_BIT];
          pol_q    <= cfg[DAC_POL_BIT];
          off_q    <= ~next_en;
        end
      end

      // slave status feeding the group stop
      assign leaving[i]  = leave_q;
      assign tracking[i] = is_track;

      assign vout_en_out[i]        = en_q;
      assign vout_en_oe_n[i]       = oe_n_q;
      assign vout_en_weak[i]       = weak_q;
      assign uv_report[i]          = uv_q;
      assign servo_enable[i]       = servo_q;
      assign dac_soft_connect[i]   = soft_q;
      assign dac_direct_connect[i] = direct_q;
      assign fast_servo_enable[i]  = fast_q;
      assign supervisor_low_res[i] = sup_q;
      assign adc_fine_res[i]       = adc_q;
      assign dac_gain_high[i]      = gain_q;
      assign dac_pol_noninv[i]     = pol_q;
      assign channel_off[i]        = off_q;
    end
  endgenerate

endmodule : chcfg_top
`default_nettype wire

// [chcfg_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module chcfg_top_checker
  import chcfg_pkg::*;
#(
  parameter logic [CNT_W-1:0] TOFF_DELAY_CYC = CNT_W'(TOFF_DELAY_CYCLES)
) (
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire logic                  clk_en,
  input wire logic [PAGE_W-1:0]     page,
  input wire logic                  cfg_wr,
  input wire logic                  cfg_rd,
  input wire logic [CFG_W-1:0]      cfg_wdata,
  input wire logic [CFG_W-1:0]      cfg_rdata,
  input wire logic                  cfg_rvalid,
  input wire logic                  input_sense_off,
  input wire logic [CHAN_COUNT-1:0] fault_in,
  input wire logic [CHAN_COUNT-1:0] vout_en_out,
  input wire logic [CHAN_COUNT-1:0] vout_en_weak,
  input wire logic [CHAN_COUNT-1:0] uv_report,
  input wire logic [CHAN_COUNT-1:0] dac_direct_connect,
  input wire logic [CHAN_COUNT-1:0] fast_servo_enable,
  input wire logic [CHAN_COUNT-1:0] adc_fine_res,
  input wire logic [CHAN_COUNT-1:0] channel_off
);
  // off delay plus sync latency and some slack
  localparam int OFF_MAX = int'(TOFF_DELAY_CYC) + 16;
  logic [CFG_W-1:0]      word_copy [CHAN_COUNT];
  logic [CFG_W-1:0]      read_copy;
  logic [CHAN_COUNT-1:0] servo_off_bits;

  // shadow of the channel words, rebuilt from write strobes only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_copy <= '{default: CFG_RESET};
      read_copy <= CFG_RESET;
    end
    else if (clk_en)
    begin
      if (cfg_wr)
        word_copy[page] <= cfg_wdata & CFG_KEEP_MASK;
      if (cfg_rd)
        read_copy <= word_copy[page];
    end
  end

  // gather the servo-disable bits so one assertion covers all channels
  always_comb
    for (int i = 0; i < CHAN_COUNT; i++)
      servo_off_bits[i] = word_copy[i][FAST_SERVO_OFF_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_read;
    clk_en && cfg_rd;
  endsequence
  sequence s_fault_ch0;
    $rose(fault_in[0]) && vout_en_out[0] && (word_copy[0][MODE_HI:MODE_LO] == SEQ_IMMEDIATE);
  endsequence

  property p_read_answer;
    s_read |=> cfg_rvalid && (cfg_rdata == read_copy);
  endproperty
  property p_reserved_zero;
    cfg_rvalid |-> (cfg_rdata[13:12] == 2'h0);
  endproperty
  property p_fast_servo;
    fast_servo_enable == ~$past(servo_off_bits);
  endproperty
  property p_adc_even;
    (adc_fine_res & 8'h55) == 8'h00;
  endproperty
  property p_upper_strong;
    vout_en_weak[7:4] == 4'h0;
  endproperty
  property p_sense_down;
    $rose(input_sense_off) |-> ##[1:OFF_MAX] (channel_off == 8'hff);
  endproperty
  property p_uv_blank;
    $rose(vout_en_out[0]) |-> (uv_report[0] == 1'b0) [*8];
  endproperty
  property p_immediate_off;
    s_fault_ch0 |-> ##[1:8] !vout_en_out[0];
  endproperty
  property p_direct_mode;
    dac_direct_connect[0] |-> (word_copy[0][DAC_MODE_HI:DAC_MODE_LO] == 2'h2);
  endproperty
  property p_weak_up;
    vout_en_out[0] && vout_en_weak[0] |-> word_copy[0][WPU_BIT];
  endproperty

  a_read_answer: assert property (p_read_answer)
    else $error("read answer wrong");
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");
  a_fast_servo: assert property (p_fast_servo)
    else $error("fast servo enable wrong");
  a_adc_even: assert property (p_adc_even)
    else $error("even channel fine adc");
  a_upper_strong: assert property (p_upper_strong)
    else $error("weak drive on upper channel");
  a_sense_down: assert property (p_sense_down)
    else $error("channels not down after input off");
  a_uv_blank: assert property (p_uv_blank)
    else $error("uv reported during rise");
  a_immediate_off: assert property (p_immediate_off)
    else $error("no immediate off on fault");
  a_direct_mode: assert property (p_direct_mode)
    else $error("direct connect in wrong mode");
  a_weak_up: assert property (p_weak_up)
    else $error("weak pull-up without enable bit");
endmodule : chcfg_top_checker

bind chcfg_top chcfg_top_checker #(.TOFF_DELAY_CYC(TOFF_DELAY_CYC)) u_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .page(page),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .input_sense_off(input_sense_off), .fault_in(fault_in),
  .vout_en_out(vout_en_out), .vout_en_weak(vout_en_weak), .uv_report(uv_report),
  .dac_direct_connect(dac_direct_connect), .fast_servo_enable(fast_servo_enable),
  .adc_fine_res(adc_fine_res), .channel_off(channel_off));
`default_nettype wire

// [chcfg_conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
module chcfg_conv_model
  import chcfg_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic [CHAN_COUNT-1:0] vout_en_out,
  input  wire logic [CHAN_COUNT-1:0] vout_en_oe_n,
  output logic      [CHAN_COUNT-1:0] uv_in,
  output logic      [CHAN_COUNT-1:0] target_reached
);
  // a three-stated enable pin is lifted by the converter's own pull-up
  wire logic [CHAN_COUNT-1:0] pin_level = vout_en_out | vout_en_oe_n;
  logic [2:0] level [CHAN_COUNT];

  // output ramps a step per cycle, slow enough to show a uv window
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      level <= '{default: 3'h0};
    else
      for (int i = 0; i < CHAN_COUNT; i++)
        if (pin_level[i] && level[i] < 3'h4)
          level[i] <= level[i] + 3'h1;
        else if (!pin_level[i] && level[i] > 3'h0)
          level[i] <= level[i] - 3'h1;
  end

  // uv while below three steps; target only at full level
  always_comb
    for (int i = 0; i < CHAN_COUNT; i++)
    begin
      uv_in[i] = level[i] < 3'h3;
      target_reached[i] = level[i] == 3'h4;
    end
endmodule : chcfg_conv_model
`default_nettype wire

// [chcfg_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module chcfg_top_bench
  import chcfg_pkg::*;
;
  logic clk_sys, reset_n, clk_en, cfg_wr, cfg_rd, cfg_rvalid, restore_user;
  logic control_input_a, control_input_b, share_clk_in, input_sense_off;
  logic [PAGE_W-1:0] page;
  logic [CFG_W-1:0] cfg_wdata, cfg_rdata;
  logic [CHAN_COUNT-1:0] op_on, fault_in, uv_in, ov_warn_in, uv_warn_in, target_reached;
  logic [CHAN_COUNT-1:0] vout_en_out, vout_en_oe_n, vout_en_weak, uv_report, servo_enable;
  logic [CHAN_COUNT-1:0] dac_soft_connect, dac_direct_connect, fast_servo_enable;
  logic [CHAN_COUNT-1:0] supervisor_low_res, adc_fine_res, dac_gain_high, dac_pol_noninv;
  logic [CHAN_COUNT-1:0] channel_off;
  int num_errors = 0;
  int total_checks = 0;

  // short counts keep the run brief
  chcfg_top #(.TON_DELAY_CYC(13'h4), .TON_RISE_CYC(13'h6), .TON_MAX_CYC(13'ha),
    .TOFF_DELAY_CYC(13'h4)) dut (.clk_sys, .reset_n, .clk_en, .page, .cfg_wr, .cfg_rd,
    .cfg_wdata, .cfg_rdata, .cfg_rvalid, .op_on, .restore_user, .control_input_a,
    .control_input_b, .share_clk_in, .input_sense_off, .fault_in, .uv_in, .ov_warn_in,
    .uv_warn_in, .target_reached, .vout_en_out, .vout_en_oe_n, .vout_en_weak, .uv_report,
    .servo_enable, .dac_soft_connect, .dac_direct_connect, .fast_servo_enable,
    .supervisor_low_res, .adc_fine_res, .dac_gain_high, .dac_pol_noninv, .channel_off);

  chcfg_conv_model conv (.clk_sys, .reset_n, .vout_en_out, .vout_en_oe_n, .uv_in,
    .target_reached);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] p, input logic [15:0] w);
    @(negedge clk_sys);
    page = p;
    cfg_wdata = w;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask : wr

  // answer is registered, so it stands at the following falling edge
  task automatic rd(input logic [2:0] p, input logic [15:0] exp);
    @(negedge clk_sys);
    page = p;
    cfg_rd = 1'b1;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    check({15'h0, cfg_rvalid}, 16'h0001);
    check(cfg_rdata, exp);
  endtask : rd

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cycles

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #(100 * 3000);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    {clk_en, reset_n, cfg_wr, cfg_rd, restore_user, input_sense_off} = 6'b100000;
    {control_input_a, control_input_b, share_clk_in} = 3'b111;
    {op_on, fault_in, ov_warn_in, uv_warn_in} = '0;
    page = '0;
    cfg_wdata = '0;
    wait_cycles(8);
    reset_n = 1'b1;
    check(fast_servo_enable, 16'h00ff);
    check(channel_off, 16'h00ff);
    for (int p = 0; p < CHAN_COUNT; p++)
      rd(p[2:0], 16'h0000);
    $display("test reset values done");
    // one word for odd pages and another for even pages, reserved bits set in every write
    for (int p = 0; p < CHAN_COUNT; p++)
      wr(p[2:0], p[0] ? 16'h3e03 : 16'h3200);
    for (int p = 0; p < CHAN_COUNT; p++)
      rd(p[2:0], p[0] ? 16'h0e03 : 16'h0200);
    wait_cycles(2);
    check(fast_servo_enable, 16'h0055);
    check(supervisor_low_res, 16'h00aa);
    check(adc_fine_res, 16'h00aa);
    check({dac_gain_high, dac_pol_noninv}, 16'haaaa);
    $display("test static fields done");
    // ch0 immediate off, direct dac, pull-up; ch1 sequenced off on pin b, weak pull-down
    wr(3'h0, 16'h0028);
    wr(3'h1, 16'h4134);
    op_on = 8'h03;
    wait_cycles(40);
    check({channel_off[1:0], vout_en_out[1:0]}, 16'h0003);
    check({dac_direct_connect[1:0], dac_soft_connect[1:0]}, 16'h0006);
    check({vout_en_oe_n[1:0], vout_en_weak[1:0]}, 16'h0009);
    control_input_b = 1'b0;
    wait_cycles(30);
    check({vout_en_out[1], vout_en_oe_n[1], vout_en_weak[1]}, 16'h0001);
    fault_in[0] = 1'b1;
    wait_cycles(8);
    check({vout_en_out[0], vout_en_oe_n[0], vout_en_weak[0]}, 16'h0000);
    op_on = 8'h00;
    fault_in = 8'h00;
    $display("test sequencing done");
    // three tracking slaves, ch4 with both weak bits stored
    wr(3'h2, 16'h8000);
    wr(3'h3, 16'h8000);
    wr(3'h4, 16'hc00c);
    op_on = 8'h1c;
    wait_cycles(40);
    check(vout_en_out[4:2], 16'h0007);
    check({vout_en_oe_n[4], vout_en_weak[4]}, 16'h0002);
    // ch5 starts on its own, not as a master; a fault on slave ch3 stops the whole
    // tracking group through its off delay
    op_on = 8'h3c;
    fault_in[3] = 1'b1;
    wait_cycles(6);
    check(vout_en_out[4:2], 16'h0007);
    wait_cycles(14);
    check(channel_off[4:2], 16'h0007);
    check(uv_report, 16'h0000);
    op_on = 8'h00;
    fault_in = 8'h00;
    $display("test tracking done");
    // ch5 re-servos on a warning only, ch6 servos continuously
    wr(3'h5, 16'h0040);
    wr(3'h6, 16'h0080);
    // each global down cause in turn
    for (int k = 0; k < 3; k++)
    begin
      op_on = 8'h60;
      wait_cycles(40);
      check(channel_off[6:5], 16'h0000);
      check(servo_enable[6:5], 16'h0002);
      uv_warn_in[5] = 1'b1;
      wait_cycles(8);
      check(servo_enable[6:5], 16'h0003);
      uv_warn_in[5] = 1'b0;
      {restore_user, share_clk_in, input_sense_off} = (k == 0) ? 3'b011 :
        ((k == 1) ? 3'b000 : 3'b110);
      wait_cycles(20);
      check(channel_off, 16'h00ff);
      {restore_user, share_clk_in, input_sense_off} = 3'b010;
      op_on = 8'h00;
      wait_cycles(4);
    end
    $display("test global down done");
    print_verdict();
  end
endmodule : chcfg_top_bench
`default_nettype wire
